// *** glue_logic_pkg.sv ***
// Package: offsets, field positions, types and carriers of the custom glue logic unit
package glue_logic_pkg;

  // Unit shape
  localparam int unsigned TABLE_COUNT      = 2;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0]  OFS_GLOBAL       = 6'h00;
  localparam logic [5:0]  OFS_SEQ          = 6'h04;
  localparam logic [5:0]  OFS_TABLE_BASE   = 6'h08;
  localparam logic [5:0]  OFS_TABLE_STRIDE = 6'h10;
  localparam logic [5:0]  OFS_FIRST        = 6'h00;
  localparam logic [5:0]  OFS_SECOND       = 6'h04;
  localparam logic [5:0]  OFS_THIRD        = 6'h08;
  localparam logic [5:0]  OFS_TRUTH        = 6'h0C;
  localparam logic [5:0]  OFS_STATUS       = 6'h28;

  // Field positions
  localparam int unsigned GLB_ENABLE_BIT   = 0;
  localparam int unsigned FIRST_ENABLE_BIT = 0;
  localparam int unsigned FIRST_EDGE_BIT   = 3;
  localparam int unsigned FIRST_FILTER_LSB = 4;
  localparam int unsigned FIRST_CLOCK_BIT  = 6;
  localparam int unsigned SEL0_LSB         = 0;
  localparam int unsigned SEL1_LSB         = 4;
  localparam int unsigned SEL2_LSB         = 0;
  localparam int unsigned SEQ_LSB          = 0;
  localparam int unsigned STATUS_OUT_LSB   = 0;
  localparam int unsigned STATUS_SEQ_BIT   = 2;

  // Input source codes
  typedef enum logic [3:0] {
    SRC_MASK       = 4'h0,
    SRC_FEEDBACK   = 4'h1,
    SRC_LINK       = 4'h2,
    SRC_EVENT0     = 4'h3,
    SRC_EVENT1     = 4'h4,
    SRC_PIN        = 4'h5,
    SRC_COMPARATOR = 4'h6,
    SRC_TIMER      = 4'h7
  } source_t;

  // Sequential element functions
  typedef enum logic [3:0] {
    SEQ_OFF    = 4'h0,
    SEQ_DFF    = 4'h1,
    SEQ_JK     = 4'h2,
    SEQ_DLATCH = 4'h3,
    SEQ_RS     = 4'h4
  } seq_func_t;

  // Output stage filter options
  typedef enum logic [1:0] {
    FILT_NONE   = 2'h0,
    FILT_SYNC   = 2'h1,
    FILT_FILTER = 2'h2
  } filter_t;

  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

  // Signal sources feeding the table inputs
  typedef struct packed {
    logic [1:0][2:0] pins;
    logic [1:0]      events;
    logic            comparator;
    logic [2:0]      timer;
  } glue_sources_t;

  // Avalon-MM request and answer
  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avalon_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avalon_rsp_t;

  // First control register of a table
  typedef struct packed {
    logic    enable;
    logic    clockSelect;
    filter_t filter;
    logic    edgeDetect;
  } table_first_t;

  // Whole state of one table
  typedef struct packed {
    table_first_t first;
    source_t      sel0;
    source_t      sel1;
    source_t      sel2;
    logic [7:0]   truth;
    logic         in2Prev;
    logic         sync1;
    logic         sync2;
    logic         filtered;
    logic         stagePrev;
  } table_state_t;

  // Whole state of the unit, bus field kept as the top bits
  typedef struct packed {
    bus_state_t                bus;
    logic [31:0]               readdata;
    logic                      globalEnable;
    seq_func_t                 seqFunc;
    table_state_t [1:0]        tables;
    logic [1:0]                outputs;
  } glue_state_t;

  // State of the sequential element
  typedef struct packed {
    logic q;
  } seq_state_t;

  // Values after reset
  localparam glue_state_t STATE_RESET = glue_state_t'({BUS_IDLE, {($bits(glue_state_t) - 2){1'b0}}});
  localparam seq_state_t  SEQ_RESET   = seq_state_t'(1'b0);

endpackage : glue_logic_pkg

// *** state_element.sv ***
// Sequential element shared by the table pair
`timescale 1ns/1ps
module state_element (
  // Clock, reset and freeze
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Control: clock and clear from the even table, function from the sequential select
  input  wire logic                   tick,
  input  wire logic                   clear,
  input  wire glue_logic_pkg::seq_func_t func,
  // Data from the tables
  input  wire logic                   dIn,
  input  wire logic                   gIn,
  // Registered output
  output logic                        q
);

  glue_logic_pkg::seq_state_t state;      // Registered state
  glue_logic_pkg::seq_state_t next_state; // Next state

  // Function selection
  always_comb begin
    next_state = state;
    if (clear) begin
      // Even table off keeps the element cleared
      next_state.q = 1'b0;
    end else begin
      case (func) // [R20]
        glue_logic_pkg::SEQ_DFF: begin
          // Capture on the table clock while gated
          if (tick && gIn) begin
            next_state.q = dIn;
          end
        end
        glue_logic_pkg::SEQ_JK: begin
          // Even output is J, odd output is K
          if (tick) begin // [R21]
            unique case ({dIn, gIn})
              2'b01: next_state.q = 1'b0;
              2'b10: next_state.q = 1'b1;
              2'b11: next_state.q = ~state.q;
              2'b00: next_state.q = state.q;
            endcase
          end
        end
        glue_logic_pkg::SEQ_DLATCH: begin
          // Transparent while gate high, sampled on every system cycle
          if (gIn) begin
            next_state.q = dIn;
          end
        end
        glue_logic_pkg::SEQ_RS: begin
          // Both high is forbidden; holding is the safe answer
          if (dIn && !gIn) begin
            next_state.q = 1'b1;
          end else if (gIn && !dIn) begin
            next_state.q = 1'b0;
          end
        end
        default: begin
          // Off or unknown code
          next_state.q = 1'b0;
        end
      endcase
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= glue_logic_pkg::SEQ_RESET;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign q = state.q;

  a_jk_toggle: assert property (@(posedge clock) disable iff (rst) // [R21]
    ce && tick && !clear && func == glue_logic_pkg::SEQ_JK && dIn && gIn |=> q == !$past(q))
    else $error("JK element did not toggle");

  a_dff_capture: assert property (@(posedge clock) disable iff (rst) // [R20]
    ce && tick && !clear && func == glue_logic_pkg::SEQ_DFF && gIn |=> q == $past(dIn))
    else $error("D flip-flop did not capture");

  a_seq_clear: assert property (@(posedge clock) disable iff (rst) // [R3]
    ce && clear |=> !q)
    else $error("Element not cleared with even table off");

endmodule : state_element

// *** custom_glue_logic.sv ***
// Custom glue logic unit: two lookup tables, sequential element, Avalon-MM registers
//
// Contract
// R1: Tables clock from peripheral clock by default
// R2: Clock select 1 clocks table from input 2
// R3: Sequential element uses even table's clock
// R4: Software disables unit before changing clock select
// R5: Debug halt does not affect operation
// R6: Sequential select writable only while even table off
// R7: Table controls except enable protected while enabled; the truth pattern here stays writable while enabled
// R8: Protected fields accept writes setting enable
// R9: Global enable bit turns unit on/off
// R10: Each table has own enable bit
// R11: Output is truth bit indexed by inputs
// R12: Masked inputs index as constant low
// R13: Inputs selectable among mask, comparator, timer, events, internal
// R14: Input 0/1 select second register, input 2 third
// R15: Feedback input takes sequential element output
// R16: Link input takes next table's output; the odd table's link input reads constant low
// R17: Per table one output, three pin inputs
// R18: Exactly two tables forming one pair
// R19: Input 2 masked while clocking the table
// R20: Sequential element offers DFF, JK, latch, RS
// R21: JK takes J from even, K from odd
// R22: Disabled table output held low
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module custom_glue_logic (
  // Clock, reset and freeze
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          ce,
  // Register bus
  input  wire glue_logic_pkg::avalon_req_t   req,
  output glue_logic_pkg::avalon_rsp_t        rsp,
  // Table input sources
  input  wire glue_logic_pkg::glue_sources_t src,
  // Table outputs toward pins
  output logic [1:0]                         tableOutput
);

  glue_logic_pkg::glue_state_t  state;      // Registered state
  glue_logic_pkg::glue_state_t  next_state; // Next state
  glue_logic_pkg::table_state_t ts;         // Table under evaluation
  logic [1:0]                   tick;       // Per table clock event
  logic [1:0]                   active;     // Per table running
  logic [1:0]                   stage;      // Per table stage output
  logic                         lastStage;  // Output of the table above
  logic                         rawIn0;     // Selected input 0
  logic                         rawIn1;     // Selected input 1
  logic                         rawIn2;     // Selected input 2 before masking
  logic [2:0]                   index;      // Truth pattern index
  logic                         lutRaw;     // Combinational table value
  logic                         filtValue;  // Filtered table value
  logic                         seqOut;     // Sequential element output
  logic [7:0]                   wd;         // Low write byte
  logic [7:0]                   rdByte;     // Assembled read byte
  logic [31:0]                  readValue;  // Read data for the current address

  // Input source multiplexer
  function automatic logic pickSource(
    input glue_logic_pkg::source_t       sel,
    input glue_logic_pkg::glue_sources_t s,
    input logic                          pin,
    input logic                          timer,
    input logic                          feedback,
    input logic                          link
  );
    case (sel) // [R13]
      glue_logic_pkg::SRC_MASK:       pickSource = 1'b0; // [R12]
      glue_logic_pkg::SRC_FEEDBACK:   pickSource = feedback; // [R15]
      glue_logic_pkg::SRC_LINK:       pickSource = link; // [R16]
      glue_logic_pkg::SRC_EVENT0:     pickSource = s.events[0];
      glue_logic_pkg::SRC_EVENT1:     pickSource = s.events[1];
      glue_logic_pkg::SRC_PIN:        pickSource = pin;
      glue_logic_pkg::SRC_COMPARATOR: pickSource = s.comparator;
      glue_logic_pkg::SRC_TIMER:      pickSource = timer;
      default:                        pickSource = 1'b0; // Reserved codes read as masked
    endcase
  endfunction : pickSource

  // Byte address of a table register
  function automatic logic [5:0] regAddr(input int n, input logic [5:0] ofs);
    regAddr = 6'(glue_logic_pkg::OFS_TABLE_BASE + glue_logic_pkg::OFS_TABLE_STRIDE * 6'(n) + ofs);
  endfunction : regAddr

  // Shared sequential element, clocked by the even table
  state_element seq (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .tick  (tick[0]), // [R3]
    .clear (~active[0]),
    .func  (state.seqFunc),
    .dIn   (stage[0]),
    .gIn   (stage[1]),
    .q     (seqOut)
  );

  // Tables, bus decode and next state
  always_comb begin
    next_state = state;
    ts         = state.tables[0];
    tick       = 2'b00;
    active     = 2'b00;
    stage      = 2'b00;
    lastStage  = 1'b0;
    rawIn0     = 1'b0;
    rawIn1     = 1'b0;
    rawIn2     = 1'b0;
    index      = 3'h0;
    lutRaw     = 1'b0;
    filtValue  = 1'b0;
    wd         = req.writedata[7:0];
    rdByte     = 8'h00;
    readValue  = 32'h0000_0000;

    // Odd table first so the even one can link to it
    for (int n = glue_logic_pkg::TABLE_COUNT - 1; n >= 0; n--) begin // [R18]
      ts     = state.tables[n];
      rawIn0 = pickSource(ts.sel0, src, src.pins[n][0], src.timer[0], seqOut, lastStage); // [R15] [R16]
      rawIn1 = pickSource(ts.sel1, src, src.pins[n][1], src.timer[1], seqOut, lastStage);
      rawIn2 = pickSource(ts.sel2, src, src.pins[n][2], src.timer[2], seqOut, lastStage);
      // Input 2 as clock: its rising edge paces the clocked stages
      tick[n] = ts.first.clockSelect ? (rawIn2 & ~ts.in2Prev) : 1'b1; // [R1] [R2]
      // Input 2 counts as low while it serves as clock
      index  = {ts.first.clockSelect ? 1'b0 : rawIn2, rawIn1, rawIn0}; // [R19] [R11]
      lutRaw = ts.truth[index]; // [R11]
      active[n] = state.globalEnable & ts.first.enable; // [R9] [R10]
      case (ts.first.filter)
        glue_logic_pkg::FILT_SYNC:   filtValue = ts.sync2;
        glue_logic_pkg::FILT_FILTER: filtValue = ts.filtered;
        default:                     filtValue = lutRaw;
      endcase
      // Edge mode gives a pulse on a rising stage value
      stage[n]  = active[n] & (ts.first.edgeDetect ? (filtValue & ~ts.stagePrev) : filtValue); // [R22]
      lastStage = stage[n];
      next_state.tables[n].in2Prev = rawIn2;
      if (!active[n]) begin
        // Internal stage logic cleared while off
        next_state.tables[n].sync1     = 1'b0;
        next_state.tables[n].sync2     = 1'b0;
        next_state.tables[n].filtered  = 1'b0;
        next_state.tables[n].stagePrev = 1'b0;
      end else if (tick[n]) begin
        // Filter accepts a value only once two samples agree
        next_state.tables[n].sync1     = lutRaw;
        next_state.tables[n].sync2     = ts.sync1;
        next_state.tables[n].filtered  = (ts.sync1 == ts.sync2) ? ts.sync2 : ts.filtered;
        next_state.tables[n].stagePrev = filtValue;
      end
    end

    // Registered pin outputs; the sequential result replaces the even table
    next_state.outputs[0] = active[0] & ((state.seqFunc != glue_logic_pkg::SEQ_OFF) ? seqOut : stage[0]); // [R17] [R22]
    next_state.outputs[1] = active[1] & stage[1]; // [R17] [R22]

    // Read data for the addressed register
    if (req.address == glue_logic_pkg::OFS_GLOBAL) begin
      readValue[glue_logic_pkg::GLB_ENABLE_BIT] = state.globalEnable;
    end else if (req.address == glue_logic_pkg::OFS_SEQ) begin
      readValue[glue_logic_pkg::SEQ_LSB +: 4] = state.seqFunc;
    end else if (req.address == glue_logic_pkg::OFS_STATUS) begin
      readValue[glue_logic_pkg::STATUS_OUT_LSB +: 2] = state.outputs;
      readValue[glue_logic_pkg::STATUS_SEQ_BIT]      = seqOut;
    end
    for (int n = 0; n < glue_logic_pkg::TABLE_COUNT; n++) begin
      rdByte = 8'h00;
      if (req.address == regAddr(n, glue_logic_pkg::OFS_FIRST)) begin
        rdByte[glue_logic_pkg::FIRST_ENABLE_BIT]      = state.tables[n].first.enable;
        rdByte[glue_logic_pkg::FIRST_EDGE_BIT]        = state.tables[n].first.edgeDetect;
        rdByte[glue_logic_pkg::FIRST_FILTER_LSB +: 2] = state.tables[n].first.filter;
        rdByte[glue_logic_pkg::FIRST_CLOCK_BIT]       = state.tables[n].first.clockSelect;
        readValue = {24'h00_0000, rdByte};
      end else if (req.address == regAddr(n, glue_logic_pkg::OFS_SECOND)) begin
        readValue = {24'h00_0000, state.tables[n].sel1, state.tables[n].sel0};
      end else if (req.address == regAddr(n, glue_logic_pkg::OFS_THIRD)) begin
        readValue = {28'h000_0000, state.tables[n].sel2};
      end else if (req.address == regAddr(n, glue_logic_pkg::OFS_TRUTH)) begin
        readValue = {24'h00_0000, state.tables[n].truth};
      end
    end

    // Bus handshake: one wait cycle, then answer and commit
    unique case (state.bus)
      glue_logic_pkg::BUS_IDLE: begin
        if (req.read || req.write) begin
          next_state.bus      = glue_logic_pkg::BUS_ANSWER;
          next_state.readdata = req.read ? readValue : 32'h0000_0000;
        end
      end
      glue_logic_pkg::BUS_ANSWER: begin
        next_state.bus = glue_logic_pkg::BUS_IDLE;
        // Only the low lane carries fields; other lanes are ignored
        if (req.write && req.byteenable[0]) begin
          if (req.address == glue_logic_pkg::OFS_GLOBAL) begin
            next_state.globalEnable = wd[glue_logic_pkg::GLB_ENABLE_BIT]; // [R9]
          end else if (req.address == glue_logic_pkg::OFS_SEQ) begin
            if (!state.tables[0].first.enable) begin // [R6]
              next_state.seqFunc = glue_logic_pkg::seq_func_t'(wd[glue_logic_pkg::SEQ_LSB +: 4]);
            end
          end
          for (int n = 0; n < glue_logic_pkg::TABLE_COUNT; n++) begin
            if (req.address == regAddr(n, glue_logic_pkg::OFS_FIRST)) begin
              next_state.tables[n].first.enable = wd[glue_logic_pkg::FIRST_ENABLE_BIT]; // [R10]
              // Protected fields pass when off, or alongside an enabling write
              if (!state.tables[n].first.enable || wd[glue_logic_pkg::FIRST_ENABLE_BIT]) begin // [R7] [R8]
                next_state.tables[n].first.edgeDetect  = wd[glue_logic_pkg::FIRST_EDGE_BIT];
                next_state.tables[n].first.filter      =
                  glue_logic_pkg::filter_t'(wd[glue_logic_pkg::FIRST_FILTER_LSB +: 2]);
                next_state.tables[n].first.clockSelect = wd[glue_logic_pkg::FIRST_CLOCK_BIT];
              end
            end else if (req.address == regAddr(n, glue_logic_pkg::OFS_SECOND)) begin
              if (!state.tables[n].first.enable) begin // [R7] [R14]
                next_state.tables[n].sel0 = glue_logic_pkg::source_t'(wd[glue_logic_pkg::SEL0_LSB +: 4]);
                next_state.tables[n].sel1 = glue_logic_pkg::source_t'(wd[glue_logic_pkg::SEL1_LSB +: 4]);
              end
            end else if (req.address == regAddr(n, glue_logic_pkg::OFS_THIRD)) begin
              if (!state.tables[n].first.enable) begin // [R7] [R14]
                next_state.tables[n].sel2 = glue_logic_pkg::source_t'(wd[glue_logic_pkg::SEL2_LSB +: 4]);
              end
            end else if (req.address == regAddr(n, glue_logic_pkg::OFS_TRUTH)) begin
              next_state.tables[n].truth = wd;
            end
          end
        end
      end
      default: begin
        // Illegal code recovers to idle
        next_state.bus = glue_logic_pkg::BUS_IDLE;
      end
    endcase
  end

  // State register; no halt input exists, so debug never stalls the unit
  always_ff @(posedge clock) begin // [R5]
    if (rst) begin
      state <= glue_logic_pkg::STATE_RESET;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign rsp.readdata    = state.readdata;
  assign rsp.waitrequest = state.bus[0];
  assign tableOutput     = state.outputs;

  a_global_off: assert property (@(posedge clock) disable iff (rst) // [R22]
    ce && !state.globalEnable |=> tableOutput == 2'b00)
    else $error("Outputs not low with unit disabled");

  a_global_write: assert property (@(posedge clock) disable iff (rst) // [R9]
    ce && state.bus == glue_logic_pkg::BUS_ANSWER && req.write && req.byteenable[0]
    && req.address == glue_logic_pkg::OFS_GLOBAL |=> state.globalEnable == $past(req.writedata[0]))
    else $error("Global enable not written");

  a_seq_protect: assert property (@(posedge clock) disable iff (rst) // [R6]
    ce && state.bus == glue_logic_pkg::BUS_ANSWER && req.write && state.tables[0].first.enable
    && req.address == glue_logic_pkg::OFS_SEQ |=> $stable(state.seqFunc))
    else $error("Sequential select changed while even table on");

  a_ctrl_protect: assert property (@(posedge clock) disable iff (rst) // [R7]
    ce && state.bus == glue_logic_pkg::BUS_ANSWER && req.write && state.tables[0].first.enable
    && req.address == regAddr(0, glue_logic_pkg::OFS_SECOND) |=> $stable(state.tables[0].sel0)
    && $stable(state.tables[0].sel1))
    else $error("Input select changed while table on");

  a_disable_write: assert property (@(posedge clock) disable iff (rst) // [R8]
    ce && state.bus == glue_logic_pkg::BUS_ANSWER && req.write && req.byteenable[0]
    && state.tables[1].first.enable && !req.writedata[0]
    && req.address == regAddr(1, glue_logic_pkg::OFS_FIRST)
    |=> !state.tables[1].first.enable && $stable(state.tables[1].first.filter)
    && $stable(state.tables[1].first.clockSelect))
    else $error("Disabling write altered protected fields");

  a_truth_index: assert property (@(posedge clock) disable iff (rst) // [R11]
    ce && active[0] && state.tables[0].sel0 == glue_logic_pkg::SRC_PIN
    && state.tables[0].sel1 == glue_logic_pkg::SRC_PIN && state.tables[0].sel2 == glue_logic_pkg::SRC_PIN
    && !state.tables[0].first.clockSelect && state.tables[0].first.filter == glue_logic_pkg::FILT_NONE
    && !state.tables[0].first.edgeDetect && state.seqFunc == glue_logic_pkg::SEQ_OFF
    |=> tableOutput[0] == $past(state.tables[0].truth[src.pins[0]]))
    else $error("Even table output does not follow truth pattern");

  a_clock_mask: assert property (@(posedge clock) disable iff (rst) // [R19]
    ce && active[1] && state.tables[1].sel0 == glue_logic_pkg::SRC_PIN
    && state.tables[1].sel1 == glue_logic_pkg::SRC_PIN && state.tables[1].first.clockSelect
    && state.tables[1].first.filter == glue_logic_pkg::FILT_NONE && !state.tables[1].first.edgeDetect
    |=> tableOutput[1] == $past(state.tables[1].truth[{1'b0, src.pins[1][1:0]}]))
    else $error("Input 2 not masked while clocking");

  a_bus_answer: assert property (@(posedge clock) disable iff (rst)
    ce && (req.read || req.write) && rsp.waitrequest |=> !rsp.waitrequest ##1 rsp.waitrequest)
    else $error("Bus answer not one cycle after request");

endmodule : custom_glue_logic

// *** glue_source_model.sv ***
// Far-side model: pin, event, comparator and timer lines feeding the tables
`timescale 1ns/1ps
module glue_source_model (
  // Clock
  input  wire logic                     clock,
  // Level pattern chosen by the bench
  input  wire logic [2:0]               level,
  // Lines toward the tables
  output glue_logic_pkg::glue_sources_t src
);
  // Lines change just after the edge, like synchronous peripheral outputs
  always @(posedge clock) begin
    src.pins       <= {level, level};
    src.events     <= level[1:0];
    src.comparator <= level[0];
    src.timer      <= level;
  end
endmodule : glue_source_model

// *** test_custom_glue_logic.sv ***
// Self-checking bench: registers over Avalon-MM, table outputs seen through status
`timescale 1ns/1ps
module test_custom_glue_logic;
  // Register addresses, derived from the package offsets
  localparam logic [5:0] G  = glue_logic_pkg::OFS_GLOBAL;
  localparam logic [5:0] SQ = glue_logic_pkg::OFS_SEQ;
  localparam logic [5:0] A1 = glue_logic_pkg::OFS_TABLE_BASE + glue_logic_pkg::OFS_FIRST;
  localparam logic [5:0] A2 = glue_logic_pkg::OFS_TABLE_BASE + glue_logic_pkg::OFS_SECOND;
  localparam logic [5:0] A3 = glue_logic_pkg::OFS_TABLE_BASE + glue_logic_pkg::OFS_THIRD;
  localparam logic [5:0] AT = glue_logic_pkg::OFS_TABLE_BASE + glue_logic_pkg::OFS_TRUTH;
  localparam logic [5:0] ST = glue_logic_pkg::OFS_STATUS;
  localparam logic [5:0] OS = glue_logic_pkg::OFS_TABLE_STRIDE; // Step to the odd table
  logic                          clock;       // System clock
  logic                          rst;         // Synchronous reset
  logic                          ce;          // Clock enable, held high
  logic [2:0]                    level;       // Pattern for the far side
  logic [7:0]                    truth;       // Random truth pattern
  logic [31:0]                   expQ[$];     // Expected answers, oldest first
  int                            nMismatch;   // Mismatches seen
  int                            nCompared;   // Comparisons made
  glue_logic_pkg::avalon_req_t   req;         // Bus request
  glue_logic_pkg::avalon_rsp_t   rsp;         // Bus answer
  glue_logic_pkg::glue_sources_t src;         // Table input lines
  logic [1:0]                    tableOutput; // Table outputs
  // Design and far side
  custom_glue_logic u_dut (.clock(clock), .rst(rst), .ce(ce), .req(req), .rsp(rsp), .src(src),
    .tableOutput(tableOutput));
  glue_source_model u_far (.clock(clock), .level(level), .src(src));
  // 4 ns clock
  always #2 clock = ~clock;
  // Verdict and end of run
  task automatic complete_run();
    if (nMismatch == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // One word compare; case equality so unknowns never match
  task automatic cmp(input logic [31:0] e, input logic [31:0] s);
    nCompared++;
    if (s !== e) begin
      nMismatch++;
      $display("mismatch readdata expected %h seen %h", e, s);
    end
  endtask : cmp
  // Pin compare, outputs are settled levels here
  task automatic cmpOut(input logic [1:0] e, input logic [1:0] s);
    nCompared++;
    if (s !== e) begin
      nMismatch++;
      $display("mismatch tableOutput expected %h seen %h", e, s);
    end
  endtask : cmpOut
  // Bus access; writes answer with zero data, so every answer is checked
  task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [31:0] e);
    expQ.push_back(wr ? 32'h0 : e);
    req.address   <= a;
    req.read      <= ~wr;
    req.write     <= wr;
    req.writedata <= {24'h0, d};
    // Hold until waitrequest is sampled low at an edge
    do @(posedge clock); while (rsp.waitrequest !== 1'b0);
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge clock);
  endtask : acc
  // Far-side level, three edges to settle, then status and pins
  task automatic drive(input logic [2:0] l, input logic [31:0] e);
    level <= l;
    repeat (3) @(posedge clock);
    acc(0, ST, 8'h00, e);
    cmpOut(e[1:0], tableOutput);
  endtask : drive
  // Watcher: pairs each answer with the oldest note
  always @(posedge clock) begin
    if (!rst && rsp.waitrequest === 1'b0) begin
      if (expQ.size() == 0) cmp(32'hFFFFFFFF, rsp.readdata);
      else cmp(expQ.pop_front(), rsp.readdata);
    end
  end
  // Watchdog, generous against about 250 expected cycles
  initial begin
    repeat (3000) @(posedge clock);
    nMismatch++;
    complete_run();
  end
  // Main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    level = 3'h0;
    req = '0;
    req.byteenable = 4'hF;
    nMismatch = 0;
    nCompared = 0;
    void'($urandom(97));
    truth = 8'($urandom());
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    acc(0, G, 8'h00, 32'h0);
    acc(0, 6'h3C, 8'h00, 32'h0);  // Unmapped reads zero
    acc(1, A2, 8'h55, 32'h0);
    acc(1, A3, 8'h05, 32'h0);
    acc(1, AT, truth, 32'h0);
    acc(1, A1, 8'h01, 32'h0);
    acc(1, G, 8'h01, 32'h0);
    // Every index from the pins
    for (int i = 0; i < 8; i++) begin
      drive(3'(i), {31'h0, truth[i]});
    end
    acc(1, A2, 8'h00, 32'h0);
    acc(0, A2, 8'h00, 32'h55);
    acc(1, SQ, 8'h01, 32'h0);
    acc(0, SQ, 8'h00, 32'h0);
    acc(1, A1, 8'h40, 32'h0);
    acc(0, A1, 8'h00, 32'h0);
    acc(1, A3, 8'h00, 32'h0);
    acc(1, A1, 8'h01, 32'h0);
    drive(3'h7, {31'h0, truth[3]});
    acc(1, G, 8'h00, 32'h0);
    drive(3'h7, 32'h0);
    acc(1, A1, 8'h41, 32'h0);
    acc(0, A1, 8'h00, 32'h41);
    acc(1, A1, 8'h00, 32'h0);
    acc(1, SQ, 8'h01, 32'h0);
    acc(0, SQ, 8'h00, 32'h1);
    // Odd table clocked from input 2, so input 2 indexes low
    acc(1, A2 + OS, 8'h55, 32'h0);
    acc(1, A3 + OS, 8'h05, 32'h0);
    acc(1, AT + OS, ~truth, 32'h0);
    acc(1, A1 + OS, 8'h41, 32'h0);
    acc(1, A1, 8'h01, 32'h0);
    acc(1, G, 8'h01, 32'h0);
    for (int i = 0; i < 8; i++) begin
      drive(3'(i), {30'h0, ~truth[i % 4], 1'b0});
    end
    // Even output follows input 0, odd follows input 1
    acc(1, AT, 8'hAA, 32'h0);
    acc(1, AT + OS, 8'hCC, 32'h0);
    // D flip-flop: data from even, gate from odd
    drive(3'h3, 32'h7);
    drive(3'h1, 32'h5);
    drive(3'h2, 32'h2);
    // JK, reselected while the even table is off
    acc(1, A1, 8'h00, 32'h0);
    acc(1, SQ, 8'h02, 32'h0);
    acc(1, A1, 8'h01, 32'h0);
    drive(3'h1, 32'h5);
    level <= 3'h3;
    repeat (5) @(posedge clock);
    drive(3'h2, 32'h2);
    // Disabling write keeps the odd clock select
    acc(1, A1 + OS, 8'h00, 32'h0);
    acc(0, A1 + OS, 8'h00, 32'h40);
    complete_run();
  end
endmodule : test_custom_glue_logic
